//--- src/pssc_core.sv
// Notes on behaviour
// - Each transaction opens with one command byte.
// - Low seven command bits give register address.
// - Command top bit: zero reads, one writes.
// - Interrupt high while flag and enable set.
// - Alarm interrupt keeps working on backup supply.
// - Low byte enable needs ram and low.
// - High byte enable needs ram and high.
// - Power transients force both memory enables inactive.
// - Missing watchdog kick within period forces reset.
// - Reset for supply, watchdog, powerup, pushbutton.
// - Debounced external reset pin gives long reset.
// - Reset held 250 ms after supply returns.
// - Serial, memory enable, kick and pushbutton inputs ignored until powerup lockout time elapses.
// - Low supply refuses serial access, holds reset.
// - Reserved addresses read zero, writes discarded.
// - Write protect bit rejects every write.
`timescale 1ns/1ps
`default_nettype none
module pssc_core #(
    parameter int RST_TICKS      = pssc_pkg::RESET_TICKS,
    parameter int LOCKOUT_TICKS  = pssc_pkg::LOCKOUT_TICKS,
    parameter int WDOG_TICKS     = pssc_pkg::WDOG_TICKS,
    parameter int DEBOUNCE_TICKS = pssc_pkg::DEBOUNCE_TICKS
) (
    // Clock and reset
    input  wire logic       mclk_i,
    input  wire logic       resetn_i,
    // Timing and supply sense
    input  wire logic       osc_i,
    input  wire logic       pfail_i,
    // Serial port
    input  wire logic       sclk_i,
    input  wire logic       cs_i,
    input  wire logic       dio_i,
    output logic            dio_o,
    output logic            dio_oe_o,
    // Processor reset pin, open drain
    input  wire logic       rst_n_i,
    output logic            rst_n_o,
    output logic            rst_n_oe_o,
    // Watchdog
    input  wire logic       watchdog_kick_in_n_i,
    // Memory enables
    input  wire logic       ram_enable_in_n_i,
    input  wire logic       low_byte_enable_in_n_i,
    input  wire logic       high_byte_enable_in_n_i,
    output logic            ram_enable_low_out_n_o,
    output logic            ram_enable_high_out_n_o,
    // Interrupt
    input  wire logic       irq_flag_i,
    input  wire logic       alarm_irq_en_i,
    output logic            int_o,
    // Register side
    input  wire logic       wp_i,
    output logic [6:0]      reg_addr_o,
    output logic [7:0]      reg_wdata_o,
    output logic            reg_we_o,
    output logic            reg_rd_o,
    input  wire logic [7:0] reg_rdata_i,
    // Status
    output logic            lockout_o
);
    localparam int MAXC = (1 << pssc_pkg::TICK_W) - 1;

    if (RST_TICKS < 1 || RST_TICKS > MAXC || LOCKOUT_TICKS < 1 || LOCKOUT_TICKS > MAXC ||
        WDOG_TICKS < 2 || WDOG_TICKS > MAXC || DEBOUNCE_TICKS < 2 || DEBOUNCE_TICKS > MAXC)
    begin : g_bad_param
        $error("pssc_core tick counts out of range");
    end

    localparam logic [15:0] RST_C = 16'(RST_TICKS);
    localparam logic [15:0] LCK_C = 16'(LOCKOUT_TICKS);
    localparam logic [15:0] WDG_C = 16'(WDOG_TICKS - 1);
    localparam logic [15:0] DEB_C = 16'(DEBOUNCE_TICKS - 1);

    logic [9:0]  sync1_r;
    logic [9:0]  sync2_r;
    logic [9:0]  pins;
    logic        osc_d_r;
    logic        kick_d_r;
    logic        tick;
    logic        pfail_s;
    logic [15:0] hold_r;
    logic [15:0] lock_r;
    logic        lockout_r;
    logic [15:0] wd_r;
    logic        wd_timeout_r;
    logic [15:0] pb_r;
    logic        pb_press_r;
    logic        pb_low;
    logic        rst_active;
    logic        rst_oe_r;
    logic        sram_block;
    logic        ce_low_n_r;
    logic        ce_high_n_r;
    logic        int_r;

    assign pins = {high_byte_enable_in_n_i, low_byte_enable_in_n_i, ram_enable_in_n_i,
                   watchdog_kick_in_n_i, rst_n_i, dio_i, cs_i, sclk_i, pfail_i, osc_i};

    // Every pin is asynchronous to the core clock.
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sync1_r <= pssc_pkg::SYNC_RST;
            sync2_r <= pssc_pkg::SYNC_RST;
        end else begin
            sync1_r <= pins;
            sync2_r <= sync1_r;
        end
    end

    assign pfail_s = sync2_r[pssc_pkg::SY_PFAIL];

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            osc_d_r  <= 1'b0;
            kick_d_r <= 1'b1;
        end else begin
            osc_d_r  <= sync2_r[pssc_pkg::SY_OSC];
            kick_d_r <= sync2_r[pssc_pkg::SY_KICK];
        end
    end

    // One pulse per oscillator period paces all supervisor delays.
    assign tick = sync2_r[pssc_pkg::SY_OSC] & ~osc_d_r;

    // Powerup lockout runs once from reset release.
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            lock_r    <= LCK_C;
            lockout_r <= 1'b1;
        end else begin
            if (tick && lock_r != 16'h0000) begin
                lock_r <= lock_r - 16'h0001;
            end
            if (lock_r == 16'h0000) begin
                lockout_r <= 1'b0;
            end
        end
    end

    // Supply fail, watchdog timeout or pushbutton press reloads the hold count; release waits for the full period after the last of them.
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            hold_r <= RST_C;
        end else if (pfail_s || wd_timeout_r || pb_press_r) begin
            hold_r <= RST_C;
        end else if (tick && hold_r != 16'h0000) begin
            hold_r <= hold_r - 16'h0001;
        end
    end

    assign rst_active = pfail_s | lockout_r | (hold_r != 16'h0000);

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_oe_r <= 1'b1;
        end else begin
            rst_oe_r <= rst_active;
        end
    end

    // Watchdog restarts on each kick falling edge and is held clear during reset.
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wd_r         <= 16'h0000;
            wd_timeout_r <= 1'b0;
        end else begin
            wd_timeout_r <= 1'b0;
            if (rst_active || (~sync2_r[pssc_pkg::SY_KICK] & kick_d_r)) begin
                wd_r <= 16'h0000;
            end else if (tick) begin
                if (wd_r == WDG_C) begin
                    wd_r         <= 16'h0000;
                    wd_timeout_r <= 1'b1;
                end else begin
                    wd_r <= wd_r + 16'h0001;
                end
            end
        end
    end

    // While the core pulls the pin itself, its low level is not a press.
    assign pb_low = ~sync2_r[pssc_pkg::SY_RSTN] & ~rst_oe_r & ~lockout_r;

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pb_r       <= 16'h0000;
            pb_press_r <= 1'b0;
        end else begin
            pb_press_r <= 1'b0;
            if (!pb_low) begin
                pb_r <= 16'h0000;
            end else if (tick) begin
                if (pb_r == DEB_C) begin
                    pb_r       <= 16'h0000;
                    pb_press_r <= 1'b1;
                end else begin
                    pb_r <= pb_r + 16'h0001;
                end
            end
        end
    end

    assign sram_block = pfail_s | lockout_r;

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ce_low_n_r  <= 1'b1;
            ce_high_n_r <= 1'b1;
        end else begin
            ce_low_n_r  <= ~(~sync2_r[pssc_pkg::SY_CEI] & ~sync2_r[pssc_pkg::SY_BLE]
                             & ~sram_block);
            ce_high_n_r <= ~(~sync2_r[pssc_pkg::SY_CEI] & ~sync2_r[pssc_pkg::SY_BHE]
                             & ~sram_block);
        end
    end

    // No supply gating here, so an alarm can wake a powered-down host.
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            int_r <= 1'b0;
        end else begin
            int_r <= irq_flag_i & alarm_irq_en_i;
        end
    end

    pssc_serial u_serial (
        .mclk_i      (mclk_i),
        .resetn_i    (resetn_i),
        .sclk_s_i    (sync2_r[pssc_pkg::SY_SCLK]),
        .cs_s_i      (sync2_r[pssc_pkg::SY_CS]),
        .dio_s_i     (sync2_r[pssc_pkg::SY_DIO]),
        .dio_o       (dio_o),
        .dio_oe_o    (dio_oe_o),
        .enable_i    (~sram_block),
        .wp_i        (wp_i),
        .reg_addr_o  (reg_addr_o),
        .reg_wdata_o (reg_wdata_o),
        .reg_we_o    (reg_we_o),
        .reg_rd_o    (reg_rd_o),
        .reg_rdata_i (reg_rdata_i)
    );

    assign rst_n_o                 = 1'b0;
    assign rst_n_oe_o              = rst_oe_r;
    assign ram_enable_low_out_n_o  = ce_low_n_r;
    assign ram_enable_high_out_n_o = ce_high_n_r;
    assign int_o                   = int_r;
    assign lockout_o               = lockout_r;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);

    sram_low_gate_a: assert property (!ram_enable_low_out_n_o |->
        $past(!sync2_r[pssc_pkg::SY_CEI] && !sync2_r[pssc_pkg::SY_BLE] && !sram_block))
        else $error("low byte enable without both inputs");
    sram_high_gate_a: assert property (!ram_enable_high_out_n_o |->
        $past(!sync2_r[pssc_pkg::SY_CEI] && !sync2_r[pssc_pkg::SY_BHE] && !sram_block))
        else $error("high byte enable without both inputs");
    sram_transient_a: assert property (sram_block |=>
        ram_enable_low_out_n_o && ram_enable_high_out_n_o)
        else $error("memory enabled during transient");
    irq_level_a: assert property ((irq_flag_i && alarm_irq_en_i)[*2] |-> int_o)
        else $error("interrupt not asserted");
    irq_drop_a: assert property (!irq_flag_i ##1 1'b1 |-> !int_o)
        else $error("interrupt stayed without flag");
    pfail_reset_a: assert property (pfail_s |=> rst_n_oe_o && hold_r == RST_C)
        else $error("supply fail did not hold reset");

    sequence supply_back_s;
        $fell(pfail_s) ##1 !pfail_s;
    endsequence
    supply_hold_a: assert property (supply_back_s |-> rst_n_oe_o && hold_r >= RST_C - 16'h0001)
        else $error("reset released early after supply return");
    wdog_force_a: assert property (wd_timeout_r |=> hold_r == RST_C ##1 rst_n_oe_o)
        else $error("watchdog timeout without reset");
    pb_force_a: assert property (pb_press_r |=> hold_r == RST_C ##1 rst_n_oe_o)
        else $error("pushbutton press without reset");
    lockout_hold_a: assert property (lockout_r |=> rst_n_oe_o)
        else $error("reset released during lockout");
    reset_cause_a: assert property (!rst_n_oe_o |-> $past(!pfail_s && hold_r == 16'h0000))
        else $error("reset released with a cause active");
endmodule // pssc_core
`default_nettype wire

//--- src/pssc_pkg.sv
`default_nettype none
package pssc_pkg;
    // Supervisor timing, counted in oscillator periods.
    localparam int OSC_HZ                  = 32768;
    localparam int RESET_TIME_MS           = 250;
    localparam int POWERUP_LOCKOUT_TIME_MS = 250;
    localparam int WDOG_TIME_MS            = 500;
    localparam int DEBOUNCE_TIME_MS        = 10;
    localparam int RESET_TICKS    = (RESET_TIME_MS * OSC_HZ + 999) / 1000;
    localparam int LOCKOUT_TICKS  = (POWERUP_LOCKOUT_TIME_MS * OSC_HZ + 999) / 1000;
    localparam int WDOG_TICKS     = (WDOG_TIME_MS * OSC_HZ) / 1000;
    localparam int DEBOUNCE_TICKS = (DEBOUNCE_TIME_MS * OSC_HZ + 999) / 1000;
    localparam int TICK_W         = 16;

    // Command byte layout.
    localparam int DATA_W       = 8;
    localparam int ADDR_W       = 7;
    localparam int REG_ADDR_LSB = 0;
    localparam int REG_ADDR_MSB = 6;
    localparam int CMD_DIR_BIT  = 7;
    localparam logic [6:0] RSVD_FIRST = 7'h0F;
    localparam logic [6:0] RSVD_LAST  = 7'h7F;
    localparam logic [2:0] LAST_BIT   = 3'h7;

    // Positions of the pins in the input synchroniser.
    localparam int SY_OSC   = 0;
    localparam int SY_PFAIL = 1;
    localparam int SY_SCLK  = 2;
    localparam int SY_CS    = 3;
    localparam int SY_DIO   = 4;
    localparam int SY_RSTN  = 5;
    localparam int SY_KICK  = 6;
    localparam int SY_CEI   = 7;
    localparam int SY_BLE   = 8;
    localparam int SY_BHE   = 9;
    localparam int SYNC_W   = 10;
    localparam logic [9:0] SYNC_RST = 10'h3E0;

    typedef enum logic [2:0] {
        SER_IDLE = 3'h0,
        SER_CMD  = 3'h1,
        SER_LOAD = 3'h2,
        SER_RD   = 3'h3,
        SER_WR   = 3'h4,
        SER_DONE = 3'h5
    } pssc_ser_state_t;

    function automatic logic addr_reserved(input logic [6:0] addr);
        addr_reserved = (addr >= RSVD_FIRST) && (addr <= RSVD_LAST);
    endfunction
endpackage
`default_nettype wire

//--- src/pssc_serial.sv
`timescale 1ns/1ps
`default_nettype none
module pssc_serial (
    // Clock and reset
    input  wire logic       mclk_i,
    input  wire logic       resetn_i,
    // Synchronised serial pins
    input  wire logic       sclk_s_i,
    input  wire logic       cs_s_i,
    input  wire logic       dio_s_i,
    output logic            dio_o,
    output logic            dio_oe_o,
    // Access gating
    input  wire logic       enable_i,
    input  wire logic       wp_i,
    // Register side
    output logic [6:0]      reg_addr_o,
    output logic [7:0]      reg_wdata_o,
    output logic            reg_we_o,
    output logic            reg_rd_o,
    input  wire logic [7:0] reg_rdata_i
);
    pssc_pkg::pssc_ser_state_t state_r;
    logic       sclk_d_r;
    logic       cs_d_r;
    logic [7:0] shift_r;
    logic [2:0] cnt_r;
    logic [6:0] addr_r;
    logic [7:0] wdata_r;
    logic       we_r;
    logic       rd_r;
    logic       dio_r;
    logic       oe_r;
    logic       sclk_rise;
    logic       sclk_fall;
    logic       cs_rise;
    logic [7:0] shift_nxt;

    assign sclk_rise = sclk_s_i & ~sclk_d_r;
    assign sclk_fall = ~sclk_s_i & sclk_d_r;
    assign cs_rise   = cs_s_i & ~cs_d_r;
    // Bits arrive least significant first.
    assign shift_nxt = {dio_s_i, shift_r[7:1]};

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sclk_d_r <= 1'b0;
            cs_d_r   <= 1'b0;
        end else begin
            sclk_d_r <= sclk_s_i;
            cs_d_r   <= cs_s_i;
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_r <= pssc_pkg::SER_IDLE;
            shift_r <= 8'h00;
            cnt_r   <= 3'h0;
            addr_r  <= 7'h00;
            wdata_r <= 8'h00;
            we_r    <= 1'b0;
            rd_r    <= 1'b0;
            dio_r   <= 1'b0;
            oe_r    <= 1'b0;
        end else begin
            we_r <= 1'b0;
            rd_r <= 1'b0;
            // A dropped select or a lost supply aborts at once.
            if (!cs_s_i || !enable_i) begin
                state_r <= pssc_pkg::SER_IDLE;
                oe_r    <= 1'b0;
            end else begin
                case (state_r)
                    pssc_pkg::SER_IDLE: begin
                        if (cs_rise) begin
                            state_r <= pssc_pkg::SER_CMD;
                            cnt_r   <= 3'h0;
                        end
                    end
                    pssc_pkg::SER_CMD: begin
                        if (sclk_rise) begin
                            shift_r <= shift_nxt;
                            cnt_r   <= cnt_r + 3'h1;
                            if (cnt_r == pssc_pkg::LAST_BIT) begin
                                addr_r <= shift_nxt[pssc_pkg::REG_ADDR_MSB:pssc_pkg::REG_ADDR_LSB];
                                if (shift_nxt[pssc_pkg::CMD_DIR_BIT]) begin
                                    state_r <= pssc_pkg::SER_WR;
                                end else begin
                                    state_r <= pssc_pkg::SER_LOAD;
                                    rd_r    <= ~pssc_pkg::addr_reserved(shift_nxt[6:0]);
                                end
                            end
                        end
                    end
                    pssc_pkg::SER_LOAD: begin
                        shift_r <= pssc_pkg::addr_reserved(addr_r) ? 8'h00 : reg_rdata_i;
                        state_r <= pssc_pkg::SER_RD;
                    end
                    pssc_pkg::SER_RD: begin
                        if (sclk_fall) begin
                            dio_r   <= shift_r[0];
                            oe_r    <= 1'b1;
                            shift_r <= {1'b0, shift_r[7:1]};
                            cnt_r   <= cnt_r + 3'h1;
                            if (cnt_r == pssc_pkg::LAST_BIT) begin
                                state_r <= pssc_pkg::SER_DONE;
                            end
                        end
                    end
                    pssc_pkg::SER_WR: begin
                        if (sclk_rise) begin
                            shift_r <= shift_nxt;
                            cnt_r   <= cnt_r + 3'h1;
                            if (cnt_r == pssc_pkg::LAST_BIT) begin
                                wdata_r <= shift_nxt;
                                we_r    <= ~wp_i & ~pssc_pkg::addr_reserved(addr_r);
                                state_r <= pssc_pkg::SER_DONE;
                            end
                        end
                    end
                    pssc_pkg::SER_DONE: begin
                        state_r <= pssc_pkg::SER_DONE;
                    end
                    default: begin
                        state_r <= pssc_pkg::SER_IDLE;
                    end
                endcase
            end
        end
    end

    assign dio_o       = dio_r;
    assign dio_oe_o    = oe_r;
    assign reg_addr_o  = addr_r;
    assign reg_wdata_o = wdata_r;
    assign reg_we_o    = we_r;
    assign reg_rd_o    = rd_r;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);

    sequence cmd_last_bit_s;
        state_r == pssc_pkg::SER_CMD && cs_s_i && enable_i && sclk_rise && cnt_r == 3'h7;
    endsequence

    cmd_addr_take_a: assert property (cmd_last_bit_s |=> reg_addr_o == $past(shift_nxt[6:0]))
        else $error("command address not captured");
    cmd_dir_read_a: assert property (cmd_last_bit_s ##0 !shift_nxt[7] |=>
        state_r == pssc_pkg::SER_LOAD || !cs_s_i || !enable_i)
        else $error("read command did not start a read");
    write_guard_a: assert property (reg_we_o |-> $past(!wp_i) && reg_addr_o < 7'h0F)
        else $error("write passed protect or reserved address");
    refuse_start_a: assert property (!enable_i |=> state_r == pssc_pkg::SER_IDLE && !dio_oe_o)
        else $error("serial access taken while refused");
    cs_low_idle_a: assert property (!cs_s_i |=> state_r == pssc_pkg::SER_IDLE)
        else $error("traffic followed without chip select");
    reserved_zero_a: assert property (state_r == pssc_pkg::SER_LOAD && reg_addr_o >= 7'h0F
        |=> shift_r == 8'h00)
        else $error("reserved read not zero");
endmodule // pssc_serial
`default_nettype wire

//--- test/pssc_host.sv
`timescale 1ns/1ps
`default_nettype none
module pssc_host (
    // Clock
    input  wire logic mclk_i,
    // Device side of the data pin
    input  wire logic dev_dio_i,
    input  wire logic dev_oe_i,
    // Serial pins as seen on the wire
    output logic      sclk_o,
    output logic      cs_o,
    output logic      dio_o
);
    logic drv;
    logic bit_v;
    logic last;

    // A released wire toggles each cycle so a stale bit can never pass as read data.
    assign dio_o = dev_oe_i ? dev_dio_i : (drv ? bit_v : ~last);

    always @(posedge mclk_i) begin
        last <= (dio_o === 1'b1);
    end

    initial begin
        sclk_o = 1'b0;
        cs_o   = 1'b0;
        drv    = 1'b0;
        bit_v  = 1'b0;
    end

    task automatic xfer(input logic sel, input logic [7:0] cmd, input logic [7:0] wd,
                        output logic [7:0] rd);
        logic [15:0] fr;
        fr = {wd, cmd};
        rd = 8'h00;
        @(negedge mclk_i);
        cs_o = sel;
        repeat (8) @(negedge mclk_i);
        for (int i = 0; i < 16; i++) begin
            sclk_o = 1'b0;
            drv    = (i < 8) || cmd[7];
            bit_v  = fr[i];
            repeat (4) @(negedge mclk_i);
            sclk_o = 1'b1;
            repeat (4) @(negedge mclk_i);
            if (i >= 8) rd[i-8] = dio_o;
        end
        sclk_o = 1'b0;
        drv    = 1'b0;
        repeat (8) @(negedge mclk_i);
        cs_o = 1'b0;
        repeat (4) @(negedge mclk_i);
    endtask
endmodule // pssc_host
`default_nettype wire

//--- test/pssc_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pssc_core_tb;
    localparam int RST_T = 8;
    localparam int LK_T  = 8;
    localparam int WD_T  = 16;
    localparam int DB_T  = 4;
    logic        mclk_i, resetn_i, osc, pfail, btn_n, kick_en, wp, ram_n, lo_n, hi_n;
    logic        flag, en, sclk, cs, dio, dev_d, dev_oe, rst_o, rst_oe, ram_enable_low_out_n, ram_enable_high_out_n;
    logic        int_o, we, rdp, lock;
    logic [6:0]  addr;
    logic [7:0]  wdata, rd;
    logic [10:0] kcnt;
    int          bad_count, n_tests, we_cnt, rd_cnt, cyc, pre, rpre;
    wire logic       rst_pin;
    wire logic       kick_n;
    wire logic [7:0] rdata;

    // The reset pin has a pull-up, so it reads high unless someone pulls it.
    assign rst_pin = rst_oe ? rst_o : btn_n;
    assign kick_n  = !(kick_en && (kcnt[9:4] == 6'h00));
    assign rdata   = {1'b0, addr} ^ 8'h5A;

    pssc_core #(.RST_TICKS(RST_T), .LOCKOUT_TICKS(LK_T), .WDOG_TICKS(WD_T),
                .DEBOUNCE_TICKS(DB_T)) i_dut (
        .mclk_i(mclk_i), .resetn_i(resetn_i), .osc_i(osc), .pfail_i(pfail),
        .sclk_i(sclk), .cs_i(cs), .dio_i(dio), .dio_o(dev_d), .dio_oe_o(dev_oe),
        .rst_n_i(rst_pin), .rst_n_o(rst_o), .rst_n_oe_o(rst_oe),
        .watchdog_kick_in_n_i(kick_n), .ram_enable_in_n_i(ram_n),
        .low_byte_enable_in_n_i(lo_n), .high_byte_enable_in_n_i(hi_n),
        .ram_enable_low_out_n_o(ram_enable_low_out_n), .ram_enable_high_out_n_o(ram_enable_high_out_n),
        .irq_flag_i(flag), .alarm_irq_en_i(en), .int_o(int_o), .wp_i(wp),
        .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_we_o(we), .reg_rd_o(rdp),
        .reg_rdata_i(rdata), .lockout_o(lock));

    pssc_host i_host (.mclk_i(mclk_i), .dev_dio_i(dev_d), .dev_oe_i(dev_oe),
        .sclk_o(sclk), .cs_o(cs), .dio_o(dio));

    initial begin
        mclk_i = 1'b0;
        forever #50 mclk_i = ~mclk_i;
    end

    initial begin
        osc = 1'b0;
        forever #15258.789 osc = ~osc;
    end

    always @(negedge mclk_i) kcnt <= kcnt + 11'h001;

    always @(posedge mclk_i) begin
        if (we === 1'b1) we_cnt++;
        if (rdp === 1'b1) rd_cnt++;
        cyc++;
        if (cyc == 60000) begin
            bad_count++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("counts: %0d compared, %0d bad", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic ticks(input int n);
        repeat (n) @(posedge osc);
        @(negedge mclk_i);
    endtask

    task automatic wr(input logic sel, input logic [7:0] cmd, input logic [7:0] d, input int n);
        pre = we_cnt;
        i_host.xfer(sel, cmd, d, rd);
        chk(8'(we_cnt - pre), 8'(n));
    endtask

    initial begin
        {resetn_i, pfail, wp, flag, en, kcnt} = '0;
        {btn_n, kick_en, ram_n, lo_n, hi_n} = 5'h1F;
        {bad_count, n_tests, we_cnt, rd_cnt, cyc} = '0;
        repeat (10) @(negedge mclk_i);
        chk(8'({lock, rst_oe, ram_enable_low_out_n, ram_enable_high_out_n, int_o}), 8'h1E);
        resetn_i = 1'b1;
        wr(1'b1, 8'h85, 8'hA5, 0);
        ticks(LK_T - 3);
        chk(8'({lock, rst_oe}), 8'h03);
        ticks(6);
        chk(8'({lock, rst_oe}), 8'h00);
        $display("test lockout done");
        for (int i = 0; i < 8; i++) begin
            {ram_n, lo_n, hi_n} = i[2:0];
            repeat (5) @(negedge mclk_i);
            chk(8'(ram_enable_low_out_n), 8'(ram_n | lo_n));
            chk(8'(ram_enable_high_out_n), 8'(ram_n | hi_n));
        end
        $display("test memory enables done");
        wr(1'b1, 8'h85, 8'hA5, 1);
        chk(8'(addr), 8'h05);
        chk(wdata, 8'hA5);
        wp = 1'b1;
        wr(1'b1, 8'h86, 8'h3C, 0);
        wp = 1'b0;
        wr(1'b1, 8'h8F, 8'h11, 0);
        wr(1'b1, 8'hFF, 8'h22, 0);
        wr(1'b0, 8'h85, 8'h33, 0);
        rpre = rd_cnt;
        wr(1'b1, 8'h03, 8'h00, 0);
        chk(rd, 8'h59);
        wr(1'b1, 8'h0F, 8'h00, 0);
        chk(rd, 8'h00);
        wr(1'b1, 8'h7F, 8'h00, 0);
        chk(rd, 8'h00);
        chk(8'(rd_cnt - rpre), 8'h01);
        $display("test serial done");
        for (int i = 0; i < 4; i++) begin
            {flag, en} = i[1:0];
            repeat (3) @(negedge mclk_i);
            chk(8'(int_o), 8'(flag & en));
        end
        $display("test interrupt done");
        {ram_n, lo_n, hi_n} = 3'h0;
        pfail = 1'b1;
        repeat (5) @(negedge mclk_i);
        chk(8'({int_o, rst_oe, ram_enable_low_out_n, ram_enable_high_out_n}), 8'h0F);
        chk(8'({rst_pin, rst_o}), 8'h00);
        wr(1'b1, 8'h85, 8'h44, 0);
        pfail = 1'b0;
        ticks(RST_T - 2);
        chk(8'(rst_oe), 8'h01);
        ticks(4);
        chk(8'({rst_oe, ram_enable_low_out_n, ram_enable_high_out_n}), 8'h00);
        $display("test power fail done");
        kick_en = 1'b0;
        ticks(WD_T - 5);
        chk(8'(rst_oe), 8'h00);
        ticks(7);
        chk(8'(rst_oe), 8'h01);
        kick_en = 1'b1;
        ticks(RST_T + 3);
        chk(8'(rst_oe), 8'h00);
        $display("test watchdog done");
        btn_n = 1'b0;
        ticks(DB_T + 3);
        chk(8'(rst_oe), 8'h01);
        btn_n = 1'b1;
        ticks(RST_T - 5);
        chk(8'(rst_oe), 8'h01);
        ticks(8);
        chk(8'(rst_oe), 8'h00);
        $display("test pushbutton done");
        give_verdict();
    end
endmodule // pssc_core_tb
`default_nettype wire
